// ==== hdl/dpc_consts.vh ====
// constants shared by the drive panel control block
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

// register byte offsets on the apb slave
`define DPC_OFS_CTRL        12'h000
`define DPC_OFS_STATUS      12'h004
`define DPC_OFS_IRQ_STAT    12'h008
`define DPC_OFS_IRQ_MASK    12'h00C

// control register fields
`define DPC_CTRL_RUN_EN     0
`define DPC_CTRL_INH_SET    1
`define DPC_CTRL_RESET      32'h00000001

// status register fields
`define DPC_ST_STATE_LSB    0
`define DPC_ST_READY        4
`define DPC_ST_ONTRACK      5
`define DPC_ST_PARK         6
`define DPC_ST_INHIBIT      7
`define DPC_ST_FAULT        8
`define DPC_ST_AT_SPEED     9
`define DPC_ST_STOPPED      10
`define DPC_ST_DOOR_LOCK    11
`define DPC_ST_MOTOR        12
`define DPC_ST_SHUTDOWN     13

// interrupt event bits
`define DPC_EV_FAULT        0
`define DPC_EV_UNDERSPEED   1
`define DPC_EV_READY        2
`define DPC_EV_PARKED       3
`define DPC_EV_WIDTH        4

// timing
`define DPC_CLK_MHZ         100
`define DPC_INDEX_LIMIT_MS  45
`define DPC_INDEX_LIMIT_CYC (`DPC_INDEX_LIMIT_MS * 1000 * `DPC_CLK_MHZ)
`define DPC_DEBOUNCE_MS     5
`define DPC_DEBOUNCE_CYC    (`DPC_DEBOUNCE_MS * 1000 * `DPC_CLK_MHZ)

`endif

// ==== hdl/dpc_debounce.v ====
// synchroniser and debouncer for front-panel switch inputs
`timescale 1ns/1ps
module dpc_debounce #(
    parameter WIDTH = 2,
    parameter COUNT = 500000
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rstn,
    // raw switches and clean results
    input  wire [WIDTH-1:0] rawIn,
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg        meta_q;
            reg        sync_q;
            reg        level_q;
            reg        rise_q;
            reg [31:0] cnt_q;
            // two-flop synchroniser, first flop feeds only the second
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= rawIn[i];
                    sync_q <= meta_q;
                end
            end
            // accept a new level only after it held for COUNT cycles
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_q   <= 32'h00000000;
                    level_q <= 1'b0;
                    rise_q  <= 1'b0;
                end else begin
                    rise_q <= 1'b0;
                    if (sync_q == level_q) begin
                        cnt_q <= 32'h00000000;
                    end else if (cnt_q >= COUNT - 1) begin
                        cnt_q   <= 32'h00000000;
                        level_q <= sync_q;
                        rise_q  <= sync_q; // one pulse per press, at its start
                    end else begin
                        cnt_q <= cnt_q + 32'h00000001;
                    end
                end
            end
            assign level[i] = level_q;
            assign rise[i]  = rise_q;
        end
    endgenerate
endmodule // dpc_debounce

// ==== hdl/dpc_index_timer.v ====
// once-per-revolution interval timer: speed and stop detection
`timescale 1ns/1ps
module dpc_index_timer #(
    parameter LIMIT = 4500000
) (
    // clock and reset
    input  wire sys_clk,
    input  wire rstn,
    // index mark and results
    input  wire indexPulse,
    output wire atSpeed,
    output wire overLimit
);
    reg        prev_q;
    reg [31:0] cnt_q;
    reg [1:0]  marks_q;
    reg        over_q;
    // count cycles since the last index edge, saturating at the limit
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev_q  <= 1'b0;
            cnt_q   <= 32'h00000000;
            marks_q <= 2'h0;
            over_q  <= 1'b1; // no marks yet: treat the spindle as stopped
        end else begin
            prev_q <= indexPulse;
            if (indexPulse && !prev_q) begin
                cnt_q  <= 32'h00000000;
                over_q <= 1'b0;
                if (marks_q != 2'h3) begin
                    marks_q <= marks_q + 2'h1;
                end
            end else if (cnt_q >= LIMIT - 1) begin
                over_q  <= 1'b1;
                marks_q <= 2'h0; // need fresh marks before speed is trusted again
            end else begin
                cnt_q <= cnt_q + 32'h00000001;
            end
        end
    end
    // a speed verdict needs three marks, so two short intervals in a row
    assign atSpeed   = (marks_q == 2'h3) && !over_q;
    assign overLimit = over_q;
endmodule // dpc_index_timer

// ==== hdl/dpc_panel_ctrl.v ====
// drive front-panel sequencing, latches, lamps and apb registers
//
// Contract
// - time index intervals; at about 45 ms call speed unsafe and cycle down
// - park position removes motor drive so the spindle coasts to a stop
// - run with interlocks safe: lock door, spin up, load heads, ready lamp
// - park: unload heads, stop rotation, unlock door once stopped, park lamp
// - inhibit press while clear sets inhibit, blocks writes, clears fault
// - inhibit press while set clears inhibit and permits writes
// - power lamp follows presence of operating power
// - ready only at speed, heads loaded, interlocks safe; drops on park
// - on-track only when ready, no seek or restore, heads settled
// - fault sets on erase/write current without write gate or dead lamp
// - fault clears on inhibit press or a park-then-run cycle
// - controller command sets inhibit; park-then-run cycle clears it
// - park lamp only with heads retracted and spindle stopped
// - write-active lamp lit for exactly each write operation
// - read-active lamp lit for exactly each read operation
// - entering run drives the positioner forward toward cylinder zero
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dpc_consts.vh"
module dpc_panel_ctrl #(
    parameter INDEX_LIMIT_CYC = `DPC_INDEX_LIMIT_CYC,
    parameter DEBOUNCE_CYC    = `DPC_DEBOUNCE_CYC
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rstn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    // front-panel switches
    input  wire        runSwitch,
    input  wire        inhibitSwitch,
    // drive sensors
    input  wire        powerOk,
    input  wire        interlocksSafe,
    input  wire        indexPulse,
    input  wire        headsLoaded,
    input  wire        headsRetracted,
    input  wire        seekBusy,
    input  wire        headsSettled,
    input  wire        eraseCurrent,
    input  wire        writeCurrent,
    input  wire        xducerLampOk,
    // controller side
    input  wire        writeGate,
    input  wire        readGate,
    input  wire        inhibitCmd,
    output reg         writeEnable,
    // actuators
    output reg         doorLock,
    output reg         motorOn,
    output reg         headsForward,
    output reg         headsRetract,
    // lamps
    output reg         readyLamp,
    output reg         on_track_lamp,
    output reg         parkLamp,
    output reg         power_present_lamp,
    output reg         write_inhibit,
    output reg         faultLamp,
    output reg         write_active_lamp,
    output reg         readActiveLamp
);
    // sequencer states
    localparam [2:0] S_PARKED   = 3'h0;
    localparam [2:0] S_SPINUP   = 3'h1;
    localparam [2:0] S_LOADING  = 3'h2;
    localparam [2:0] S_READY    = 3'h3;
    localparam [2:0] S_UNLOAD   = 3'h4;
    localparam [2:0] S_SPINDOWN = 3'h5;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg         shutdown_q;
    reg         runCycle;
    reg  [31:0] ctrl_q;
    reg  [`DPC_EV_WIDTH-1:0] irqStat_q;
    reg  [`DPC_EV_WIDTH-1:0] irqMask_q;
    reg  [`DPC_EV_WIDTH-1:0] events;
    reg  [31:0] readMux;
    reg         mapped;
    wire [1:0]  swLevel;
    wire [1:0]  swRise;
    wire        atSpeed;
    wire        stopped;
    wire        runSel;
    wire        inhPress;
    wire        setup;
    wire        access;
    wire        wrAcc;
    wire        rdAcc;
    wire        inhSetSw;
    wire        faultCause;
    wire        underspeed;

    // switch conditioning
    dpc_debounce #(
        .WIDTH (2),
        .COUNT (DEBOUNCE_CYC)
    ) uDeb (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .rawIn   ({inhibitSwitch, runSwitch}),
        .level   (swLevel),
        .rise    (swRise)
    );
    assign runSel   = swLevel[0] && ctrl_q[`DPC_CTRL_RUN_EN];
    assign inhPress = swRise[1];

    // spindle speed watch
    dpc_index_timer #(
        .LIMIT (INDEX_LIMIT_CYC)
    ) uIdx (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .indexPulse (indexPulse),
        .atSpeed    (atSpeed),
        .overLimit  (stopped)
    );
    // once up to speed, a long interval means unsafe speed
    assign underspeed = stopped && ((state_q == S_LOADING) || (state_q == S_READY));

    // apb phases; pready is high in the first access cycle, so there are no wait states
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign wrAcc  = access && pwrite;
    assign rdAcc  = access && !pwrite;
    assign inhSetSw = wrAcc && (paddr == `DPC_OFS_CTRL) && pwdata[`DPC_CTRL_INH_SET];

    // sequencer next state
    always @* begin
        state_d  = state_q;
        runCycle = 1'b0;
        case (state_q)
            S_PARKED: begin
                // shutdown latch forces a trip through park before restart
                if (runSel && interlocksSafe && !shutdown_q) begin
                    state_d  = S_SPINUP;
                    runCycle = 1'b1;
                end
            end
            S_SPINUP: begin
                if (!runSel || !interlocksSafe) begin
                    state_d = S_SPINDOWN;
                end else if (atSpeed) begin
                    state_d = S_LOADING;
                end
            end
            S_LOADING: begin
                if (!runSel || !interlocksSafe || underspeed) begin
                    state_d = S_UNLOAD;
                end else if (headsLoaded) begin
                    state_d = S_READY;
                end
            end
            S_READY: begin
                if (!runSel || !interlocksSafe || underspeed || !headsLoaded) begin
                    state_d = S_UNLOAD;
                end
            end
            S_UNLOAD: begin
                if (headsRetracted) begin
                    state_d = S_SPINDOWN;
                end
            end
            S_SPINDOWN: begin
                // door stays locked until the spindle has really stopped
                if (stopped) begin
                    state_d = S_PARKED;
                end
            end
            default: begin
                state_d = S_UNLOAD;
            end
        endcase
    end

    // sequencer state and shutdown latch
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= S_PARKED;
            shutdown_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (underspeed) begin
                shutdown_q <= 1'b1;
            end else if (!swLevel[0]) begin
                shutdown_q <= 1'b0;
            end
        end
    end

    // actuators follow the sequencer state
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            doorLock     <= 1'b0;
            motorOn      <= 1'b0;
            headsForward <= 1'b0;
            headsRetract <= 1'b0;
        end else begin
            doorLock     <= (state_d != S_PARKED);
            motorOn      <= (state_d == S_SPINUP) || (state_d == S_LOADING) ||
                            (state_d == S_READY);
            headsForward <= (state_d == S_LOADING);
            headsRetract <= (state_d == S_UNLOAD);
        end
    end

    // fault and inhibit latches; a set in the same cycle beats a clear
    assign faultCause = ((eraseCurrent || writeCurrent) && !writeGate) || !xducerLampOk;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            faultLamp     <= 1'b0;
            write_inhibit <= 1'b0;
        end else begin
            if (faultCause) begin
                faultLamp <= 1'b1;
            end else if (inhPress || runCycle) begin
                faultLamp <= 1'b0;
            end
            if (inhibitCmd || inhSetSw) begin
                write_inhibit <= 1'b1;
            end else if (inhPress) begin
                write_inhibit <= !write_inhibit;
            end else if (runCycle) begin
                write_inhibit <= 1'b0;
            end
        end
    end

    // lamps and write permission
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            readyLamp          <= 1'b0;
            on_track_lamp      <= 1'b0;
            parkLamp           <= 1'b0;
            power_present_lamp <= 1'b0;
            writeEnable        <= 1'b0;
            write_active_lamp  <= 1'b0;
            readActiveLamp     <= 1'b0;
        end else begin
            readyLamp          <= (state_d == S_READY);
            on_track_lamp      <= (state_d == S_READY) && !seekBusy && headsSettled;
            parkLamp           <= (state_d == S_PARKED) && headsRetracted && stopped;
            power_present_lamp <= powerOk;
            writeEnable        <= (state_d == S_READY) && !write_inhibit &&
                                  !inhibitCmd;
            write_active_lamp  <= writeGate && (state_d == S_READY) && !write_inhibit;
            readActiveLamp     <= readGate && (state_d == S_READY);
        end
    end

    // interrupt events: fault, underspeed, ready reached, parked reached
    always @* begin
        events = {`DPC_EV_WIDTH{1'b0}};
        events[`DPC_EV_FAULT]      = faultCause && !faultLamp;
        events[`DPC_EV_UNDERSPEED] = underspeed;
        events[`DPC_EV_READY]      = (state_d == S_READY) && (state_q != S_READY);
        events[`DPC_EV_PARKED]     = (state_d == S_PARKED) && (state_q != S_PARKED);
    end

    // status word for software
    always @* begin
        readMux = 32'h00000000;
        readMux[`DPC_ST_STATE_LSB+2:`DPC_ST_STATE_LSB] = state_q;
        readMux[`DPC_ST_READY]     = readyLamp;
        readMux[`DPC_ST_ONTRACK]   = on_track_lamp;
        readMux[`DPC_ST_PARK]      = parkLamp;
        readMux[`DPC_ST_INHIBIT]   = write_inhibit;
        readMux[`DPC_ST_FAULT]     = faultLamp;
        readMux[`DPC_ST_AT_SPEED]  = atSpeed;
        readMux[`DPC_ST_STOPPED]   = stopped;
        readMux[`DPC_ST_DOOR_LOCK] = doorLock;
        readMux[`DPC_ST_MOTOR]     = motorOn;
        readMux[`DPC_ST_SHUTDOWN]  = shutdown_q;
    end

    // address decode for the data captured in setup
    always @* begin
        mapped = 1'b1;
        case (paddr)
            `DPC_OFS_CTRL:     mapped = 1'b1;
            `DPC_OFS_STATUS:   mapped = 1'b1;
            `DPC_OFS_IRQ_STAT: mapped = 1'b1;
            `DPC_OFS_IRQ_MASK: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    // apb handshake and read data, captured at setup so outputs are flops
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                case (paddr)
                    `DPC_OFS_CTRL:     prdata <= ctrl_q;
                    `DPC_OFS_STATUS:   prdata <= readMux;
                    `DPC_OFS_IRQ_STAT: prdata <= {28'h0000000, irqStat_q};
                    `DPC_OFS_IRQ_MASK: prdata <= {28'h0000000, irqMask_q};
                    default:           prdata <= 32'h00000000;
                endcase
            end else if (!psel) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // software registers; inhibit-set bit is a self-clearing command
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q    <= `DPC_CTRL_RESET;
            irqMask_q <= {`DPC_EV_WIDTH{1'b0}};
            irqStat_q <= {`DPC_EV_WIDTH{1'b0}};
            irq       <= 1'b0;
        end else begin
            if (wrAcc && (paddr == `DPC_OFS_CTRL)) begin
                ctrl_q <= {31'h00000000, pwdata[`DPC_CTRL_RUN_EN]};
            end
            if (wrAcc && (paddr == `DPC_OFS_IRQ_MASK)) begin
                irqMask_q <= pwdata[`DPC_EV_WIDTH-1:0];
            end
            // read clears only the bits it reported; events since setup survive
            if (rdAcc && (paddr == `DPC_OFS_IRQ_STAT)) begin
                irqStat_q <= (irqStat_q & ~prdata[`DPC_EV_WIDTH-1:0]) | events;
            end else begin
                irqStat_q <= irqStat_q | events;
            end
            irq <= |((irqStat_q | events) & irqMask_q);
        end
    end
endmodule // dpc_panel_ctrl

// ==== testbench/dpc_ctrl_model.sv ====
// disk controller model: read and write gates and the inhibit command
`timescale 1ns/1ps
module dpc_ctrl_model (
    // clock and reset
    input  wire  sys_clk,
    input  wire  rstn,
    // bench requests and drive permission
    input  wire  wrReq,
    input  wire  rdReq,
    input  wire  protReq,
    input  wire  writeEnable,
    // controller outputs to the drive
    output logic writeGate,
    output logic readGate,
    output logic inhibitCmd
);
    // gates follow requests; a write is only started while the drive permits it
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            writeGate  <= 1'h0;
            readGate   <= 1'h0;
            inhibitCmd <= 1'h0;
        end else begin
            writeGate  <= wrReq && writeEnable;
            readGate   <= rdReq;
            inhibitCmd <= protReq;
        end
    end
endmodule // dpc_ctrl_model

// ==== testbench/dpc_panel_ctrl_assertions.sv ====
// concurrent checks on the drive panel control ports
`timescale 1ns/1ps
module dpc_panel_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // sensors and controller
    input wire logic powerOk,
    input wire logic seekBusy,
    input wire logic headsRetracted,
    input wire logic eraseCurrent,
    input wire logic writeCurrent,
    input wire logic xducerLampOk,
    input wire logic writeGate,
    input wire logic readGate,
    input wire logic inhibitCmd,
    // actuators and lamps
    input wire logic doorLock,
    input wire logic motorOn,
    input wire logic readyLamp,
    input wire logic on_track_lamp,
    input wire logic parkLamp,
    input wire logic power_present_lamp,
    input wire logic write_inhibit,
    input wire logic faultLamp,
    input wire logic write_active_lamp,
    input wire logic readActiveLamp
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // one wait-free access cycle, then pready falls
    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not in first access cycle");
    apb_err_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    ready_lock_a: assert property (readyLamp |-> doorLock && !parkLamp)
        else $error("ready lamp without door lock");
    on_track_a: assert property (on_track_lamp |-> readyLamp && !$past(seekBusy))
        else $error("on-track lamp during seek or without ready");
    park_lamp_a: assert property (parkLamp |-> !doorLock && !motorOn && $past(headsRetracted))
        else $error("park lamp while spinning or heads out");
    write_lamp_a: assert property (write_active_lamp |-> $past(writeGate))
        else $error("write lamp without write gate");
    read_lamp_a: assert property ($fell(readGate) |=> !readActiveLamp)
        else $error("read lamp outlasts read");
    power_lamp_a: assert property ($past(rstn) |-> power_present_lamp == $past(powerOk))
        else $error("power lamp does not follow power");
    inhibit_cmd_a: assert property (inhibitCmd |=> write_inhibit)
        else $error("inhibit command ignored");
    fault_set_a: assert property ((eraseCurrent || writeCurrent) && !writeGate
        || !xducerLampOk |=> faultLamp)
        else $error("fault cause did not set fault lamp");
    // main scenarios reached
    cover property ($rose(readyLamp));
    cover property ($rose(parkLamp));
    cover property ($rose(faultLamp));
endmodule // dpc_panel_assertions

bind dpc_panel_ctrl dpc_panel_assertions chk (.sys_clk, .rstn, .psel, .penable, .pready,
    .pslverr, .powerOk, .seekBusy, .headsRetracted, .eraseCurrent, .writeCurrent,
    .xducerLampOk, .writeGate, .readGate, .inhibitCmd, .doorLock, .motorOn, .readyLamp,
    .on_track_lamp, .parkLamp, .power_present_lamp, .write_inhibit, .faultLamp,
    .write_active_lamp, .readActiveLamp);

// ==== testbench/dpc_panel_ctrl_test.sv ====
// self-checking bench for the drive panel control block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge sys_clk); n++; end \
    if (!(c)) begin errCount++; $display("[ERR] %0t wait timed out", $time); end end
module dpc_panel_ctrl_test;
    // clock, counters, apb
    logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
    int          errCount = 0, checked = 0, n, i;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, rd;
    // switches, sensors, controller requests
    logic runSwitch = 0, inhibitSwitch = 0, powerOk = 1, interlocksSafe = 1, indexPulse = 0;
    logic headsLoaded = 0, seekBusy = 0, headsSettled = 1, eraseCurrent = 0, writeCurrent = 0;
    logic xducerLampOk = 1, slow = 0, wrReq = 0, rdReq = 0, protReq = 0;
    logic [8:0] idxCnt = 9'h000;
    wire  headsRetracted = !headsLoaded;
    wire  [31:0] prdata;
    wire  pready, pslverr, irq, writeGate, readGate, inhibitCmd, writeEnable, doorLock, motorOn;
    wire  headsForward, headsRetract, readyLamp, on_track_lamp, parkLamp, power_present_lamp;
    wire  write_inhibit, faultLamp, write_active_lamp, readActiveLamp;
    // rows {wr, rd, seek, settled, write lamp, read lamp, on-track}
    logic [6:0] rows [5] = '{7'h4D, 7'h2B, 7'h18, 7'h66, 7'h09};

    always #5 sys_clk = ~sys_clk;
    // spindle: a mark every 100 cycles, 300 when slowed (past the 200 limit)
    always @(posedge sys_clk) begin
        idxCnt     <= (idxCnt >= (slow ? 9'h12B : 9'h063)) ? 9'h000 : idxCnt + 9'h001;
        indexPulse <= motorOn && idxCnt == 9'h000;
    end
    // positioner: heads load when driven forward, unload when retracted
    always @(posedge sys_clk) begin
        if (headsForward) headsLoaded <= 1'h1;
        else if (headsRetract) headsLoaded <= 1'h0;
    end

    dpc_ctrl_model ctl (.sys_clk, .rstn, .wrReq, .rdReq, .protReq, .writeEnable, .writeGate,
        .readGate, .inhibitCmd);
    dpc_panel_ctrl #(.INDEX_LIMIT_CYC(200), .DEBOUNCE_CYC(4)) dut (.sys_clk, .rstn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .runSwitch,
        .inhibitSwitch, .powerOk, .interlocksSafe, .indexPulse, .headsLoaded, .headsRetracted,
        .seekBusy, .headsSettled, .eraseCurrent, .writeCurrent, .xducerLampOk, .writeGate,
        .readGate, .inhibitCmd, .writeEnable, .doorLock, .motorOn, .headsForward, .headsRetract,
        .readyLamp, .on_track_lamp, .parkLamp, .power_present_lamp, .write_inhibit, .faultLamp,
        .write_active_lamp, .readActiveLamp);

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge sys_clk);
            psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'h1;
            // no cycle count assumed: only the watchdog ends this wait
            do begin @(posedge sys_clk); end while (pready !== 1'h1);
            rd = prdata; err = pslverr;
            psel <= 1'h0; penable <= 1'h0;
        end
    endtask
    // held well past the debounce span: one press must act once
    task press;
        begin
            inhibitSwitch <= 1'h1; repeat (12) @(posedge sys_clk);
            inhibitSwitch <= 1'h0; repeat (12) @(posedge sys_clk); #1;
        end
    endtask
    task giveVerdict;
        begin
            $display("checks %0d errors %0d", checked, errCount);
            if (errCount == 0 && checked > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // watchdog, far beyond the expected few thousand cycles
    initial begin
        #300000; errCount++; giveVerdict;
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        apb(1'h1, 12'h00C, 32'h0000000F);
        apb(1'h0, 12'h008, 32'h0);
        apb(1'h0, 12'h010, 32'h0); // unmapped: refused, reads zero
        `CHK({err, rd}, 33'h100000000)
        runSwitch <= 1'h1;
        `WAITC(readyLamp) repeat (2) @(posedge sys_clk); #1;
        `CHK({doorLock, motorOn, headsLoaded, parkLamp, irq}, 5'h1D)
        apb(1'h0, 12'h008, 32'h0);
        `CHK(rd[2], 1'h1)
        repeat (2) @(posedge sys_clk); #1;
        `CHK(irq, 1'h0)
        for (i = 0; i < 5; i++) begin
            {wrReq, rdReq, seekBusy, headsSettled} <= rows[i][6:3];
            repeat (4) @(posedge sys_clk); #1;
            `CHK({write_active_lamp, readActiveLamp, on_track_lamp}, rows[i][2:0])
        end
        {wrReq, rdReq} <= 2'h0;
        // fault event, masked then unmasked
        apb(1'h1, 12'h00C, 32'h0);
        eraseCurrent <= 1'h1; @(posedge sys_clk); eraseCurrent <= 1'h0;
        repeat (3) @(posedge sys_clk); #1;
        `CHK({faultLamp, irq}, 2'h2)
        apb(1'h1, 12'h00C, 32'h1); repeat (2) @(posedge sys_clk); #1;
        `CHK(irq, 1'h1)
        apb(1'h0, 12'h008, 32'h0); repeat (2) @(posedge sys_clk); #1;
        `CHK({rd[0], irq}, 2'h2)
        press;
        `CHK({write_inhibit, faultLamp, writeEnable}, 3'h4)
        press;
        `CHK({write_inhibit, writeEnable}, 2'h1)
        protReq <= 1'h1; @(posedge sys_clk); protReq <= 1'h0;
        xducerLampOk <= 1'h0; @(posedge sys_clk); xducerLampOk <= 1'h1;
        repeat (3) @(posedge sys_clk); #1;
        `CHK({write_inhibit, faultLamp, writeEnable}, 3'h6)
        // park, then run again: latches clear
        runSwitch <= 1'h0;
        `WAITC(!motorOn) #1;
        `CHK(readyLamp, 1'h0)
        `WAITC(parkLamp) #1;
        `CHK({doorLock, motorOn, headsLoaded, parkLamp}, 4'h1)
        runSwitch <= 1'h1;
        `WAITC(doorLock) #1;
        `CHK({write_inhibit, faultLamp}, 2'h0)
        `WAITC(readyLamp)
        // register inhibit set, then status readback
        apb(1'h1, 12'h000, 32'h00000003);
        apb(1'h0, 12'h004, 32'h0);
        `CHK({rd[7], rd[4], rd[2:0]}, 5'h1B)
        // interlock opens: ready drops, door held until stopped, then restart
        interlocksSafe <= 1'h0;
        `WAITC(!readyLamp) #1;
        `CHK({motorOn, doorLock}, 2'h1)
        interlocksSafe <= 1'h1;
        `WAITC(readyLamp) #1;
        `CHK(write_inhibit, 1'h0)
        // underspeed: shutdown, run refused until the switch goes to park
        slow <= 1'h1;
        `WAITC(!motorOn) #1;
        `CHK({readyLamp, motorOn}, 2'h0)
        slow <= 1'h0; repeat (400) @(posedge sys_clk); #1;
        `CHK(motorOn, 1'h0)
        runSwitch <= 1'h0; repeat (2) @(posedge sys_clk);
        // second reset while parked, with the run switch at park
        rstn <= 1'h0; @(posedge sys_clk); #1;
        `CHK({doorLock, motorOn, readyLamp, write_inhibit, faultLamp, writeEnable, irq}, 7'h0)
        @(posedge sys_clk);
        rstn <= 1'h1;
        repeat (2) @(posedge sys_clk); #1;
        `CHK(power_present_lamp, 1'h1)
        powerOk <= 1'h0; repeat (2) @(posedge sys_clk); #1;
        `CHK(power_present_lamp, 1'h0)
        giveVerdict;
    end
endmodule // dpc_panel_ctrl_test
